// [bench/adc_seq_props.sv]
`timescale 1ns/1ps

// ********************
// Port checker
// ********************
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                reset_n_i,
    input wire logic                conversion_start_n_i,
    input wire logic                read_n_i,
    input wire logic                chip_select_n_i,
    input wire logic                ext_clk_i,
    input wire logic                clock_source_select_i,
    input wire logic [RESULT_W-1:0] sample_i,
    input wire logic                end_of_conversion_n_o,
    input wire logic                last_conversion_done_n_o,
    input wire logic [RESULT_W-1:0] result_bus_o,
    input wire logic                result_bus_oe_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [3:0] since_q;

    // Cycles since the last external clock rise, saturating
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            since_q <= 4'hF;
        end else if ($rose(ext_clk_i)) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hF) begin
            since_q <= since_q + 4'h1;
        end
    end

    a_bus_release: assert property ((read_n_i || chip_select_n_i) [*4] |-> !result_bus_oe_o)
        else $error("bus driven while read idle");
    a_bus_drive: assert property ((!read_n_i && !chip_select_n_i) [*4] |-> result_bus_oe_o)
        else $error("bus not driven during read");
    a_result_hold: assert property (result_bus_oe_o && $past(result_bus_oe_o) |-> $stable(result_bus_o))
        else $error("result changed during read");
    a_eoc_int_width: assert property ($fell(end_of_conversion_n_o) && clock_source_select_i
        |=> !end_of_conversion_n_o ##1 end_of_conversion_n_o)
        else $error("internal end pulse width wrong");
    a_eoc_ext_edge: assert property ($fell(end_of_conversion_n_o) && !clock_source_select_i
        |-> since_q <= 4'h7)
        else $error("end of conversion without clock edge");
    a_eoc_marks_last: assert property ($fell(end_of_conversion_n_o) |-> !last_conversion_done_n_o)
        else $error("last done not low at end");
    a_last_on_start: assert property ($fell(conversion_start_n_i) |-> ##[3:5] last_conversion_done_n_o)
        else $error("last done not released by start");
    a_eoc_in_acq: assert property (!conversion_start_n_i [*5] |-> end_of_conversion_n_o)
        else $error("end of conversion during acquisition");
endmodule // adc_seq_checker

bind adc_conversion_sequencer adc_seq_checker u_chk (.*);

// [bench/host_model.sv]
`timescale 1ns/1ps

// ********************
// Host side: conversion clock and inverted read-back of a floating bus
// ********************
module host_model
    import adc_seq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                run_i,
    input  wire logic                oe_i,
    input  wire logic [RESULT_W-1:0] bus_i,
    output logic                     ext_clk_o,
    output logic [RESULT_W-1:0]      bus_o
);
    logic [2:0]          div_q;
    logic [RESULT_W-1:0] last_q;

    // Clock of 8 cycles, parked low between frames, first rise 4 cycles in
    always_ff @(posedge clk_i) begin
        div_q  <= run_i ? div_q + 3'h1 : 3'h0;
        last_q <= oe_i ? bus_i : last_q;
    end
    assign ext_clk_o = div_q[2];
    // A floating bus must not look like a stale word, so read back its inverse
    assign bus_o = oe_i ? bus_i : ~last_q;
endmodule // host_model

// [bench/test_adc_conversion_sequencer.sv]
`timescale 1ns/1ps

// ********************
// Sequencer testbench
// ********************
module test_adc_conversion_sequencer
    import adc_seq_pkg::*;
;
    logic                clk    = 1'b0;
    logic                rst_n  = 1'b0;
    logic                st_n   = 1'b1;
    logic                rd_n   = 1'b1;
    logic                cs_n   = 1'b1;
    logic                sel    = 1'b0;
    logic                run    = 1'b0;
    logic [RESULT_W-1:0] sample = 14'h0000;
    logic                eoc_n, last_n, oe, ext_clk;
    logic [RESULT_W-1:0] rbus, hbus;
    int                  err_count = 0;
    int                  checked   = 0;
    int                  edges     = 0;

    // 25 MHz clock and external edge count
    always #20 clk = ~clk;
    always @(posedge ext_clk) edges++;

    adc_conversion_sequencer dut (
        .clk_i(clk), .reset_n_i(rst_n), .conversion_start_n_i(st_n), .read_n_i(rd_n),
        .chip_select_n_i(cs_n), .ext_clk_i(ext_clk), .clock_source_select_i(sel),
        .sample_i(sample), .end_of_conversion_n_o(eoc_n), .last_conversion_done_n_o(last_n),
        .result_bus_o(rbus), .result_bus_oe_o(oe));
    host_model u_host (.clk_i(clk), .run_i(run), .oe_i(oe), .bus_i(rbus),
        .ext_clk_o(ext_clk), .bus_o(hbus));

    task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for the end pulse; a hang ends the run
    task automatic wait_eoc(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (eoc_n !== 1'b0 && n < 400);
        if (eoc_n !== 1'b0) begin
            err_count++;
            $display("[FAIL] %0t no end of conversion", $time);
            results();
        end
    endtask

    // Acquire for 6 cycles (at least 4 needed), then convert and time it
    task automatic convert(input logic mode, input logic [RESULT_W-1:0] smp);
        int n;
        int w;
        @(posedge clk);
        sel    <= mode;
        sample <= smp;
        st_n   <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check(last_n, 1'b1);
        @(posedge clk);
        st_n <= 1'b1;
        run  <= 1'b1;
        edges = 0;
        wait_eoc(n);
        if (mode)
            check(n >= CONV_INT_CYCLES && n <= CONV_INT_CYCLES + 8, 1'b1);
        else
            check(edges, 16);
        check(last_n, 1'b0);
        w = 0;
        while (eoc_n === 1'b0 && w < 50) begin
            @(negedge clk);
            w++;
        end
        if (mode)
            check(w, EOC_INT_CYCLES);
        else
            check(w >= 7 && w <= 9, 1'b1);
        @(posedge clk);
        run <= 1'b0;
    endtask

    // One read; chip select high must keep the bus released
    task automatic read_check(input logic cs, input logic [RESULT_W-1:0] exp);
        @(posedge clk);
        cs_n <= cs;
        rd_n <= 1'b0;
        repeat (4) @(negedge clk);
        check(oe, !cs);
        if (!cs)
            check(hbus, exp);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(negedge clk);
        check(oe, 1'b0);
    endtask

    // Hold a read open so results pile up until the buffer refuses
    task automatic fill_check;
        int n;
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        // Output stage holds one word beyond the memory words
        for (int i = 0; i <= FIFO_DEPTH; i++)
            convert(1'b1, RESULT_W'(i + 1));
        check(hbus, 14'h1FFF);
        @(posedge clk);
        st_n   <= 1'b0;
        sample <= 14'h3FFF;
        repeat (6) @(posedge clk);
        st_n <= 1'b1;
        n = 0;
        repeat (100) begin
            @(negedge clk);
            n += (eoc_n === 1'b0);
        end
        check(n, 0);
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wait_eoc(n);
        repeat (40) @(negedge clk);
        read_check(1'b0, 14'h3FFF);
    endtask

    task automatic results;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        convert(1'b0, 14'h2A5C);
        read_check(1'b0, 14'h2A5C);
        read_check(1'b0, 14'h2A5C);
        read_check(1'b1, 14'h0000);
        convert(1'b1, 14'h1FFF);
        read_check(1'b0, 14'h1FFF);
        fill_check();
        results();
    end
endmodule // test_adc_conversion_sequencer

// [common/adc_seq_pkg.sv]
package adc_seq_pkg;

    // ***************************************************************
    // Widths and depths
    // ***************************************************************
    localparam int RESULT_W   = 14;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 6;

    // ***************************************************************
    // Timing, clock at 25 MHz
    // ***************************************************************
    localparam int CLK_MHZ     = 25;
    localparam int CONV_INT_NS = 1600;  // Internal-clock conversion time
    localparam int EOC_INT_NS  = 80;    // Least end-of-conversion low time
    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] CONV_INT_CYCLES =
        CNT_W'((CONV_INT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] EOC_INT_CYCLES =
        CNT_W'((EOC_INT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] EXT_CONV_EDGES = 6'h10;  // External clocks per conversion

    // ***************************************************************
    // Reset values
    // ***************************************************************
    localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;

    // ***************************************************************
    // Carriers
    // ***************************************************************
    typedef struct packed {
        logic conversion_start_n;
        logic read_n;
        logic chip_select_n;
        logic ext_clk;
        logic clock_source_select;
    } host_pins_s;

    typedef struct packed {
        logic [RESULT_W-1:0] code;
    } result_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQUIRE,
        ST_CONVERT,
        ST_PUSH,
        ST_EOC
    } conv_state_e;

endpackage

// [hw/adc_conversion_sequencer.sv]
`timescale 1ns/1ps

module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                conversion_start_n_i,
    input  wire logic                read_n_i,
    input  wire logic                chip_select_n_i,
    input  wire logic                ext_clk_i,
    input  wire logic                clock_source_select_i,
    input  wire logic [RESULT_W-1:0] sample_i,
    output logic                     end_of_conversion_n_o,
    output logic                     last_conversion_done_n_o,
    output logic [RESULT_W-1:0]      result_bus_o,
    output logic                     result_bus_oe_o
);

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    host_pins_s pins_raw;
    host_pins_s sync1_q, sync2_q, prev_q;

    assign pins_raw = '{conversion_start_n  : conversion_start_n_i,
                        read_n              : read_n_i,
                        chip_select_n       : chip_select_n_i,
                        ext_clk             : ext_clk_i,
                        clock_source_select : clock_source_select_i};

    // Two stages before any logic; third stage feeds edge detection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            sync2_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            prev_q  <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    logic start_fall, start_rise, ext_rise;

    // Edge strobes from the settled stages only
    assign start_fall = !sync2_q.conversion_start_n && prev_q.conversion_start_n;
    assign start_rise = sync2_q.conversion_start_n && !prev_q.conversion_start_n;
    assign ext_rise   = sync2_q.ext_clk && !prev_q.ext_clk;

    // ***************************************************************
    // Conversion sequencer
    // ***************************************************************
    conv_state_e         st_q, st_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic                int_mode_q, int_mode_d;
    logic [RESULT_W-1:0] held_q, held_d;
    logic                eoc_n_q, eoc_n_d;
    logic                last_n_q, last_n_d;
    logic                tick;
    logic                fifo_in_ready;
    result_s             fifo_in, fifo_out;
    logic                fifo_out_valid;
    logic                oe_q, oe_d;
    logic [RESULT_W-1:0] result_q, result_d;

    // One conversion step: every cycle inside, rising edges outside
    assign tick = int_mode_q ? 1'b1 : ext_rise;

    // Next state of the sequencer
    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        int_mode_d = int_mode_q;
        held_d     = held_q;
        eoc_n_d    = eoc_n_q;
        last_n_d   = last_n_q;
        // New sequence clears the last-done flag
        if (start_fall) begin
            last_n_d = 1'b1;
        end
        unique case (st_q)
            ST_IDLE: begin
                if (start_fall) begin
                    st_d = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE: begin
                // An early start may cut into the end pulse; let it run out
                if (!eoc_n_q && tick) begin
                    cnt_d = cnt_q + CNT_W'(1);
                    if (!int_mode_q || cnt_d == EOC_INT_CYCLES) begin
                        eoc_n_d = 1'b1;
                    end
                end
                // Rising start ends tracking and freezes the sample
                if (start_rise) begin
                    held_d     = sample_i;
                    int_mode_d = sync2_q.clock_source_select;
                    cnt_d      = '0;
                    st_d       = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    cnt_d = cnt_q + CNT_W'(1);
                    if (cnt_d == (int_mode_q ? CONV_INT_CYCLES : EXT_CONV_EDGES)) begin
                        st_d = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                // A full FIFO holds the end pulse back until it drains
                if (fifo_in_ready) begin
                    eoc_n_d  = 1'b0;
                    last_n_d = 1'b0;
                    cnt_d    = '0;
                    st_d     = ST_EOC;
                end
            end
            ST_EOC: begin
                if (tick) begin
                    cnt_d = cnt_q + CNT_W'(1);
                    // External: one clock period; internal: least pulse time
                    if (!int_mode_q || cnt_d == EOC_INT_CYCLES) begin
                        eoc_n_d = 1'b1;
                        st_d    = start_fall ? ST_ACQUIRE : ST_IDLE;
                    end
                end else if (start_fall) begin
                    st_d = ST_ACQUIRE;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q       <= ST_IDLE;
            cnt_q      <= '0;
            int_mode_q <= 1'b0;
            held_q     <= RESULT_RST;
            eoc_n_q    <= 1'b1;
            last_n_q   <= 1'b1;
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            int_mode_q <= int_mode_d;
            held_q     <= held_d;
            eoc_n_q    <= eoc_n_d;
            last_n_q   <= last_n_d;
        end
    end

    assign end_of_conversion_n_o    = eoc_n_q;
    assign last_conversion_done_n_o = last_n_q;

    // ***************************************************************
    // Result buffer
    // ***************************************************************
    assign fifo_in.code = held_q;

    result_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_result_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_data_i   (fifo_in),
        .in_valid_i  (st_q == ST_PUSH),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!oe_q)
    );

    // ***************************************************************
    // Parallel read port
    // ***************************************************************

    // Result only changes while the bus is idle, so a read never tears
    always_comb begin
        oe_d     = !sync2_q.read_n && !sync2_q.chip_select_n;
        result_d = (fifo_out_valid && !oe_q) ? fifo_out.code : result_q;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_q     <= 1'b0;
            result_q <= RESULT_RST;
        end else begin
            oe_q     <= oe_d;
            result_q <= result_d;
        end
    end

    assign result_bus_o    = result_q;
    assign result_bus_oe_o = oe_q;

endmodule // adc_conversion_sequencer

// [hw/result_fifo.sv]
`timescale 1ns/1ps

// ***************************************************************
// Result FIFO with registered read data
// ***************************************************************
module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic             ov_q, ov_d;
    logic             push, pop;

    // Honest full: only the memory words count, not the output stage
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_data_o  = out_q;
    assign out_valid_o = ov_q;

    // Pointer, count and output stage next values
    always_comb begin
        push  = in_valid_i && in_ready_o;
        pop   = (cnt_q != '0) && (!ov_q || out_ready_i);
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        out_d = pop ? mem_q[rd_q] : out_q;
        ov_d  = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
    end

    // Registers; memory words carry no reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            out_q <= '0;
            ov_q  <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ov_q  <= ov_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

endmodule // result_fifo
